// >>> logic/aes_block_cipher_control.sv
// Register control, key and state memories of the block cipher engine
`timescale 1ns/100ps
`default_nettype none
`include "crypt_ctl_map.svh"

module aes_block_cipher_control
	import crypt_ctl_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        reset,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// Requests to the system
	output logic             irq,
	output logic      [1:0]  irq_level,
	output logic             dma_req,
	output logic             busy
);

	// Bus pipeline state
	logic        ph_q;       // Data phase pending
	logic        wr_q;       // Data phase is a write
	logic [2:0]  idx_q;      // Register index
	logic        rdy_out_q;  // Registered hreadyout
	logic [31:0] rdata_q;    // Registered read data
	logic        resp_q;     // Always OKAY

	// Control and flags
	eng_state_e  st_q;       // Engine state
	eng_state_e  st_d;
	logic        auto_q;     // Self-launch enable
	logic        dir_q;      // Zero encrypts
	logic        xor_q;      // Combine-load mode
	logic        srst_q;     // Soft reset pulse
	logic        err_q;      // Error flag
	logic        err_d;
	logic        rdy_q;      // Result ready flag
	logic        rdy_d;
	logic [1:0]  lvl_q;      // Interrupt level
	logic [1:0]  lvl_d;
	logic        irq_q;      // Interrupt line
	logic [8:0]  cnt_q;      // Run cycle counter
	logic [3:0]  acc_q;      // Window accesses mod 16

	// Pointers and memories
	ptr_t        s_wp_q;     // State write pointer
	ptr_t        s_rp_q;     // State read pointer
	ptr_t        k_wp_q;     // Key write pointer
	ptr_t        k_rp_q;     // Key read pointer
	byte_t       s_mem [16]; // State memory
	byte_t       k_mem [16]; // Key memory

	// Decode
	wire         acc_now;
	wire  [2:0]  idx_in;
	wire         wr_ev;
	wire         rd_ev;
	wire         any_ev;
	wire         running;
	wire         ctl_ev;
	wire         flg_wr;
	wire         lvl_wr;
	wire         s_ev;
	wire         s_wr;
	wire         s_rd;
	wire         k_ev;
	wire         k_wr;
	wire         k_rd;
	wire  [7:0]  wdata;
	wire         wipe;
	wire         busy_err;
	wire         go_wr;
	wire         cnt_err;
	wire         go_man;
	wire         auto_go;
	wire         done;
	wire         err_set;
	wire         srst_wr;
	wire         rdy_clr;
	wire         err_clr;
	wire  [3:0]  s_rp_nx;
	wire  [7:0]  s_wval;
	wire  [7:0]  ctl_rd;
	wire  [7:0]  rd_byte;

	// Transfer taken in address phase
	assign acc_now = hsel & htrans[1] & hready;
	// Out-of-range addresses land on a reserved index
	assign idx_in  = (haddr[31:5] == 27'h0) ? haddr[4:2] : 3'h7;
	// Writes act in the data phase, reads in their wait cycle
	assign wr_ev   = ph_q & wr_q;
	assign rd_ev   = ph_q & ~wr_q & ~rdy_out_q;
	assign any_ev  = wr_ev | rd_ev;
	assign wdata   = hwdata[7:0];
	assign wipe    = reset | srst_q;
	assign running = (st_q == ENG_RUN);

	// Register selects
	assign ctl_ev  = any_ev & (idx_q == `CRYPT_IDX_CTRL);
	assign flg_wr  = wr_ev & (idx_q == `CRYPT_IDX_FLAGS);
	assign lvl_wr  = wr_ev & (idx_q == `CRYPT_IDX_IRQ);
	// Windows are dead while the engine runs
	assign s_ev    = any_ev & (idx_q == `CRYPT_IDX_STATE) & ~running;
	assign k_ev    = any_ev & (idx_q == `CRYPT_IDX_KEY) & ~running;
	assign s_wr    = s_ev & wr_q;
	assign s_rd    = s_ev & ~wr_q;
	assign k_wr    = k_ev & wr_q;
	assign k_rd    = k_ev & ~wr_q;

	// Any control access while running is illegal and stops the run
	assign busy_err = ctl_ev & running;
	// Explicit start, soft reset takes precedence
	assign go_wr   = ctl_ev & wr_q & ~running & wdata[`CRYPT_CTRL_RUN] & ~wdata[`CRYPT_CTRL_SRST];
	// Count taken before this access clears it
	assign cnt_err = go_wr & (acc_q != 4'h0);
	assign go_man  = go_wr & (acc_q == 4'h0);
	assign srst_wr = ctl_ev & wr_q & wdata[`CRYPT_CTRL_SRST];

	// State read pointer after this write
	assign s_rp_nx = xor_q ? s_rp_q + 4'h1 : s_rp_q;
	// Last state byte written with all pointers landing on zero
	assign auto_go = auto_q & s_wr & (s_wp_q == 4'hf) & (s_rp_nx == 4'h0)
		& (k_wp_q == 4'h0) & (k_rp_q == 4'h0);

	// Run completes on its last counted cycle
	assign done    = running & (cnt_q == `CRYPT_RUN_CYCLES - 9'd1);
	assign err_set = busy_err | cnt_err;

	// Flag clears; a set in the same cycle wins
	assign rdy_clr = (s_rd & (s_rp_q == 4'h0)) | (flg_wr & wdata[`CRYPT_FLAG_RDY]);
	assign err_clr = flg_wr & wdata[`CRYPT_FLAG_ERR];

	// Combine-load merges with the stored byte
	assign s_wval  = xor_q ? (s_mem[s_wp_q] ^ wdata) : wdata;

	// Control read view; reserved bits are zero
	assign ctl_rd  = {running, auto_q, srst_q, dir_q, 1'b0, xor_q, 2'b00};

	// Read mux; reserved offsets and blocked windows return zero
	assign rd_byte =
		(idx_q == `CRYPT_IDX_CTRL)  ? ctl_rd :
		(idx_q == `CRYPT_IDX_FLAGS) ? {err_q, 6'h00, rdy_q} :
		(idx_q == `CRYPT_IDX_STATE) ? (running ? 8'h00 : s_mem[s_rp_q]) :
		// After a run the key memory still holds the key bytes as loaded
		(idx_q == `CRYPT_IDX_KEY)   ? (running ? 8'h00 : k_mem[k_rp_q]) :
		(idx_q == `CRYPT_IDX_IRQ)   ? {6'h00, lvl_q} :
		8'h00;

	// Engine sequencing
	always_comb begin
		st_d = st_q;
		case (st_q)
			ENG_IDLE: begin
				// Manual or self launch
				if ((go_man | auto_go) & ~err_set) begin
					st_d = ENG_RUN;
				end
			end
			ENG_RUN: begin
				// Abort, error or completion drop the run bit
				if (err_set | done) begin
					st_d = ENG_IDLE;
				end
			end
			default: begin
				st_d = ENG_IDLE;
			end
		endcase
	end

	// Flag next values
	always_comb begin
		rdy_d = rdy_q;
		err_d = err_q;
		lvl_d = lvl_q;
		if (rdy_clr) begin
			rdy_d = 1'b0;
		end
		if (done) begin
			rdy_d = 1'b1;
		end
		if (err_clr) begin
			err_d = 1'b0;
		end
		if (err_set) begin
			err_d = 1'b1;
		end
		if (lvl_wr) begin
			lvl_d = wdata[1:0];
		end
	end

	// Bus pipeline; hard reset only, so a soft reset never tears a transfer
	always_ff @(posedge clk) begin
		if (reset) begin
			ph_q      <= 1'b0;
			wr_q      <= 1'b0;
			idx_q     <= 3'h0;
			rdy_out_q <= 1'b1;
			resp_q    <= 1'b0;
		end else if (hready) begin
			ph_q      <= acc_now;
			wr_q      <= hwrite;
			idx_q     <= idx_in;
			// Reads take one wait state for registered data
			rdy_out_q <= ~(acc_now & ~hwrite);
		end else begin
			rdy_out_q <= 1'b1;
		end
	end

	// Read data register
	always_ff @(posedge clk) begin
		if (reset) begin
			rdata_q <= 32'h0000_0000;
		end else if (rd_ev) begin
			rdata_q <= {24'h00_0000, rd_byte};
		end
	end

	// Engine state and run counter
	always_ff @(posedge clk) begin
		if (wipe) begin
			st_q  <= ENG_IDLE;
			cnt_q <= 9'd0;
		end else begin
			st_q  <= st_d;
			// Counter restarts at each launch
			cnt_q <= running ? cnt_q + 9'd1 : 9'd0;
		end
	end

	// Control bits, written only while idle
	always_ff @(posedge clk) begin
		if (wipe) begin
			auto_q <= 1'b0;
			dir_q  <= 1'b0;
			xor_q  <= 1'b0;
		end else if (ctl_ev & wr_q & ~running & ~srst_wr) begin
			auto_q <= wdata[`CRYPT_CTRL_AUTO];
			dir_q  <= wdata[`CRYPT_CTRL_DIR];
			xor_q  <= wdata[`CRYPT_CTRL_XOR];
		end
	end

	// Soft reset pulse, self-clearing through wipe
	always_ff @(posedge clk) begin
		if (wipe) begin
			srst_q <= 1'b0;
		end else begin
			srst_q <= srst_wr;
		end
	end

	// Flags and interrupt
	always_ff @(posedge clk) begin
		if (wipe) begin
			rdy_q <= 1'b0;
			err_q <= 1'b0;
			lvl_q <= 2'b00;
			irq_q <= 1'b0;
		end else begin
			rdy_q <= rdy_d;
			err_q <= err_d;
			lvl_q <= lvl_d;
			// Built from next values so it tracks the flag exactly
			irq_q <= rdy_d & (lvl_d != 2'b00);
		end
	end

	// Pointers and access count
	always_ff @(posedge clk) begin
		if (wipe | ctl_ev) begin
			s_wp_q <= `CRYPT_RST_PTR;
			s_rp_q <= `CRYPT_RST_PTR;
			k_wp_q <= `CRYPT_RST_PTR;
			k_rp_q <= `CRYPT_RST_PTR;
			acc_q  <= 4'h0;
		end else begin
			// Natural 4-bit wrap after sixteen accesses
			if (s_wr) begin
				s_wp_q <= s_wp_q + 4'h1;
				s_rp_q <= s_rp_nx;
			end else if (s_rd) begin
				s_rp_q <= s_rp_q + 4'h1;
			end
			if (k_wr) begin
				k_wp_q <= k_wp_q + 4'h1;
			end else if (k_rd) begin
				k_rp_q <= k_rp_q + 4'h1;
			end
			if (s_ev | k_ev) begin
				acc_q <= acc_q + 4'h1;
			end
		end
	end

	// Memories in flip-flops
	always_ff @(posedge clk) begin
		if (wipe) begin
			for (int i = 0; i < 16; i++) begin
				s_mem[i] <= `CRYPT_RST_BYTE;
				k_mem[i] <= `CRYPT_RST_BYTE;
			end
		end else begin
			if (s_wr) begin
				s_mem[s_wp_q] <= s_wval;
			end
			if (k_wr) begin
				k_mem[k_wp_q] <= wdata;
			end
		end
	end

	// Outputs
	assign hrdata    = rdata_q;
	assign hreadyout = rdy_out_q;
	assign hresp     = resp_q;
	assign irq       = irq_q;
	assign irq_level = lvl_q;
	assign dma_req   = rdy_q;
	assign busy      = running;

	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	// Launch of the engine
	sequence s_go;
		!running ##1 running;
	endsequence
	// Run finishing with a ready flag
	sequence s_finish;
		running && cnt_q == `CRYPT_RUN_CYCLES - 9'd1 && !err_set && !srst_q;
	endsequence
	// Start on a clean count
	a_start_sets_run: assert property (go_man && !srst_q |=> running)
		else $error("start write did not set run");
	// Abort through control access
	a_abort_on_write: assert property (ctl_ev && wr_q && running && !srst_q |=> !running && err_q)
		else $error("run not aborted by control write");
	// Flags drop run
	a_flag_drops_run: assert property ($rose(rdy_q) || $rose(err_q) |-> !running)
		else $error("run still set with flag raised");
	// Self launch
	a_auto_launch: assert property (auto_go && !srst_q |=> running ##0 cnt_q == 9'd0)
		else $error("self launch missed");
	// Soft reset wipe
	a_soft_wipe: assert property (srst_q |=> !running && !auto_q && !err_q
		&& s_wp_q == 4'h0 && k_mem[0] == 8'h00)
		else $error("soft reset left state");
	// One cycle pulse
	a_srst_pulse: assert property (srst_wr && !srst_q |=> srst_q ##1 !srst_q)
		else $error("soft reset bit not a single pulse");
	// Direction stored
	a_dir_store: assert property (ctl_ev && wr_q && !running && !srst_wr && !srst_q
		|=> dir_q == $past(wdata[`CRYPT_CTRL_DIR]))
		else $error("direction bit not stored");
	// Combine-load merge
	a_xor_merge: assert property (s_wr && xor_q && !srst_q
		|=> s_mem[$past(s_wp_q)] == ($past(wdata) ^ $past(s_mem[s_wp_q])))
		else $error("combine load wrong");
	// Bad count flags error and blocks the run
	a_count_error: assert property (cnt_err && !srst_q |=> err_q && !running)
		else $error("count error missed");
	// Error on control access while busy
	a_busy_access: assert property (busy_err && !srst_q |=> err_q)
		else $error("busy control access not flagged");
	// Ready flag after exactly the run length
	a_done_cycle: assert property (s_go |-> cnt_q == 9'd0)
		else $error("run counter not zero at launch");
	a_ready_time: assert property (s_finish |=> rdy_q && !running)
		else $error("ready not raised at run end");
	// Ready clear on first state byte
	a_ready_clear: assert property (s_rd && s_rp_q == 4'h0 && !done && !srst_q |=> !rdy_q)
		else $error("ready not cleared by state read");
	// Windows inert while busy
	a_window_lock: assert property (running && !ctl_ev && !srst_q
		|=> $stable(s_wp_q) && $stable(k_wp_q) && $stable(acc_q))
		else $error("window moved while running");
	// Control access zeroes pointers
	a_ptr_clear: assert property (ctl_ev && !reset |=> s_wp_q == 4'h0 && s_rp_q == 4'h0
		&& k_wp_q == 4'h0 && k_rp_q == 4'h0)
		else $error("pointers not cleared");
	// Interrupt line relation
	a_irq_line: assert property (irq == (rdy_q && lvl_q != 2'b00))
		else $error("interrupt line mismatch");

endmodule : aes_block_cipher_control
`default_nettype wire

// >>> logic/crypt_ctl_map.svh
// Register map, field positions and timing counts of the cipher control block
// Notes on behaviour
// - Writing run bit starts; reads one while busy
// - Writing run zero while busy aborts
// - Ready or error flag clears run bit
// - Self-launch when filled with all pointers zero
// - Soft reset wipes all but the bus pipeline next clock edge
// - Soft reset bit reads high one cycle
// - Direction bit: zero encrypts, one decrypts
// - Combine-load XORs state writes, else replaces
// - Start with access count not multiple-16 errors
// - Control access while running sets error
// - Error flag cleared by writing one
// - Ready flag set on completion; DMA request
// - Ready clears on first state read, write-one
// - Windows inert while running; host stays off
// - Key window returns the loaded key bytes after run
// - Nonzero level field enables interrupt on ready
// - Result ready 375 cycles after start
// - Four 4-bit pointers, increment and wrap
// - Control access zeroes all four pointers
// - Combine-load write advances both state pointers
`ifndef CRYPT_CTL_MAP_SVH
`define CRYPT_CTL_MAP_SVH

// Register indices; byte address is four times the index
`define CRYPT_IDX_CTRL   3'h0
`define CRYPT_IDX_FLAGS  3'h1
`define CRYPT_IDX_STATE  3'h2
`define CRYPT_IDX_KEY    3'h3
`define CRYPT_IDX_IRQ    3'h4

// Control register fields
`define CRYPT_CTRL_RUN   7
`define CRYPT_CTRL_AUTO  6
`define CRYPT_CTRL_SRST  5
`define CRYPT_CTRL_DIR   4
`define CRYPT_CTRL_XOR   2

// Flag register fields
`define CRYPT_FLAG_ERR   7
`define CRYPT_FLAG_RDY   0

// Reset values
`define CRYPT_RST_BYTE   8'h00
`define CRYPT_RST_PTR    4'h0

// Engine run length in peripheral clock cycles
`define CRYPT_RUN_CYCLES 9'd375

`endif

// >>> logic/crypt_ctl_pkg.sv
// Types shared by the cipher control block
`default_nettype none
package crypt_ctl_pkg;

	// Engine state
	typedef enum logic [0:0] {
		ENG_IDLE = 1'b0,
		ENG_RUN  = 1'b1
	} eng_state_e;

	// One byte of a memory
	typedef logic [7:0] byte_t;

	// Memory pointer
	typedef logic [3:0] ptr_t;

endpackage : crypt_ctl_pkg
`default_nettype wire

// >>> verification/ahb_host.sv
// Bus master model standing in for the host processor on the register bus
`timescale 1ns/100ps
`default_nettype none

module ahb_host (
	// Clock
	input  wire logic        clk,
	// Request side of the bus
	output logic             hsel,
	output logic      [31:0] haddr,
	output logic      [1:0]  htrans,
	output logic             hwrite,
	output logic      [2:0]  hsize,
	output logic      [31:0] hwdata,
	// Answer side of the bus
	input  wire logic        hready,
	input  wire logic [31:0] hrdata
);
	// Bus idle from time zero
	initial begin
		hsel   <= 1'b0;
		haddr  <= 32'h0;
		htrans <= 2'h0;
		hwrite <= 1'b0;
		hsize  <= 3'h2;
		hwdata <= 32'h0;
	end

	// Waits for hready sampled high at an edge; bounded so a dead slave cannot hang us
	task automatic wait_ready(output logic ok);
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (hready !== 1'b1 && n < 64);
		ok = (hready === 1'b1);
	endtask : wait_ready

	// One single word transfer; caller enters just after a rising edge
	// Window accesses while the engine runs are issued only by scenarios that expect refusal
	task automatic xfer(input logic wr, input logic [2:0] idx, input logic [7:0] wd,
		output logic [31:0] rd, output logic ok);
		hsel   <= 1'b1;
		haddr  <= {27'h0, idx, 2'h0};
		htrans <= 2'h2;
		hwrite <= wr;
		hsize  <= 3'h2;
		wait_ready(ok);
		// Address phase taken: release it, present write data
		htrans <= 2'h0;
		hsel   <= 1'b0;
		hwdata <= {24'h0, wd};
		if (ok) begin
			wait_ready(ok);
		end
		// Read data taken at the same edge that ends the data phase
		rd = hrdata;
	endtask : xfer
endmodule : ahb_host

`default_nettype wire

// >>> verification/tb_top.sv
// Self-checking bench for the cipher control block
`timescale 1ns/100ps
`default_nettype none
`include "crypt_ctl_map.svh"

module tb_top;
	// Register indices and control values
	localparam logic [2:0] i_ctl = `CRYPT_IDX_CTRL;
	localparam logic [2:0] i_flg = `CRYPT_IDX_FLAGS;
	localparam logic [2:0] i_st  = `CRYPT_IDX_STATE;
	localparam logic [2:0] i_key = `CRYPT_IDX_KEY;
	localparam logic [2:0] i_irq = `CRYPT_IDX_IRQ;
	localparam logic [7:0] run_b = 8'h01 << `CRYPT_CTRL_RUN;
	localparam logic [7:0] err_b = 8'h01 << `CRYPT_FLAG_ERR;

	logic        clk   = 1'b0;  // Bench clock
	logic        reset = 1'b1;  // Held high for three cycles
	logic        hsel, hwrite, hready, hresp, irq, dma_req, busy;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0]  htrans, irq_level;
	logic [2:0]  hsize;
	logic [7:0]  kb [16];       // Key bytes
	logic [7:0]  sb [16];       // State bytes
	logic [7:0]  xb [16];       // Combine bytes, later the expected combined state
	logic [31:0] rv;            // Last read value
	int          n;             // Measured run length
	int          err_total = 0;
	int          n_tests   = 0;

	// 100 MHz clock
	always #5 clk = ~clk;

	ahb_host host (.clk(clk), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata));

	aes_block_cipher_control uut (.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .irq(irq), .irq_level(irq_level),
		.dma_req(dma_req), .busy(busy));

	// Single verdict point
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : end_of_test

	// Compares one value and counts
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// One bus access; a bus timeout ends the run
	task automatic acc(input logic wr, input logic [2:0] idx, input logic [7:0] wd);
		logic ok;
		host.xfer(wr, idx, wd, rv, ok);
		if (!ok) begin
			err_total++;
			$display("mismatch at %0t: bus timeout", $time);
			end_of_test();
		end
	endtask : acc

	// Read and compare one register
	task automatic rd_chk(input logic [2:0] idx, input logic [7:0] exp);
		acc(1'b0, idx, 8'h00);
		check(rv, {24'h0, exp});
	endtask : rd_chk

	// Sixteen sequential window writes
	task automatic load(input logic [2:0] idx, ref logic [7:0] b [16]);
		for (int i = 0; i < 16; i++) begin
			acc(1'b1, idx, b[i]);
		end
	endtask : load

	// Sixteen sequential window reads
	task automatic read16(input logic [2:0] idx, ref logic [7:0] b [16]);
		for (int i = 0; i < 16; i++) begin
			rd_chk(idx, b[i]);
		end
	endtask : read16

	// Counts edges with the engine running; a run that never starts leaves zero
	task automatic run_len(output int c);
		c = 0;
		for (int t = 0; t < 1000; t++) begin
			@(posedge clk);
			if (busy === 1'b1) begin
				c++;
			end else if (c > 0) begin
				break;
			end
		end
		// A run that never starts or never ends closes the test
		if (c == 0 || busy === 1'b1) begin
			err_total++;
			$display("mismatch at %0t: run length timeout", $time);
			end_of_test();
		end
	endtask : run_len

	// Expected state byte after a combine-load write
	function automatic logic [7:0] merged(input logic [7:0] held, input logic [7:0] fresh);
		return held ^ fresh;
	endfunction : merged

	// Main sequence
	initial begin
		void'($urandom(32'h65c5));
		foreach (kb[i]) begin
			kb[i] = 8'($urandom);
			sb[i] = 8'($urandom);
			xb[i] = 8'($urandom);
		end
		// Corner bytes among the random ones
		xb[0]  = 8'hff;
		sb[15] = 8'h00;
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		// Everything reads zero after reset, reserved places included; control read last clears pointers
		for (int i = 7; i >= 0; i--) begin
			rd_chk(3'(i), 8'h00);
		end
		check({hresp, busy, irq, dma_req}, 4'h0);
		// Level field keeps two bits only
		acc(1'b1, i_irq, 8'hff);
		rd_chk(i_irq, 8'h03);
		check(irq_level, 2'h3);
		acc(1'b1, i_irq, 8'h02);
		// Reserved control bits drop, direction and combine kept
		acc(1'b1, i_ctl, 8'h1f);
		rd_chk(i_ctl, 8'h14);
		// Decrypt chosen before loading
		acc(1'b1, i_ctl, 8'h10);
		load(i_key, kb);
		load(i_st, sb);
		acc(1'b1, i_ctl, run_b | 8'h10);
		run_len(n);
		check(n, 375);
		check({busy, dma_req, irq}, 3'b011);
		rd_chk(i_flg, 8'h01);
		rd_chk(i_ctl, 8'h10);
		// Write-one clears ready and withdraws the request
		acc(1'b1, i_flg, 8'h01);
		@(posedge clk);
		check({dma_req, irq}, 2'b00);
		read16(i_st, sb);
		read16(i_key, kb);
		rd_chk(i_st, sb[0]);
		// Access count now 33: start refused with error
		acc(1'b1, i_ctl, run_b);
		@(posedge clk);
		check(busy, 1'b0);
		rd_chk(i_flg, err_b);
		acc(1'b1, i_flg, 8'h00);
		rd_chk(i_flg, err_b);
		acc(1'b1, i_flg, err_b);
		rd_chk(i_flg, 8'h00);
		// Combine-load over the stored state
		acc(1'b1, i_ctl, 8'h04);
		load(i_st, xb);
		foreach (xb[i]) begin
			xb[i] = merged(sb[i], xb[i]);
		end
		read16(i_st, xb);
		rd_chk(i_st, xb[0]);
		rd_chk(i_ctl, 8'h04);
		rd_chk(i_st, xb[0]);
		// Start, then windows refused, then abort by control write
		acc(1'b1, i_ctl, 8'h00);
		acc(1'b1, i_ctl, run_b);
		@(posedge clk);
		check(busy, 1'b1);
		acc(1'b1, i_st, 8'h5a);
		rd_chk(i_key, 8'h00);
		acc(1'b1, i_ctl, 8'h00);
		@(posedge clk);
		check({busy, dma_req}, 2'b00);
		rd_chk(i_flg, err_b);
		acc(1'b1, i_flg, err_b);
		rd_chk(i_ctl, 8'h00);
		rd_chk(i_st, xb[0]);
		// Soft reset wipes registers and memories
		acc(1'b1, i_ctl, 8'h20);
		@(posedge clk);
		rd_chk(i_ctl, 8'h00);
		rd_chk(i_st, 8'h00);
		rd_chk(i_key, 8'h00);
		rd_chk(i_irq, 8'h00);
		// Self-launch after a full load from zero pointers
		acc(1'b1, i_irq, 8'h01);
		acc(1'b1, i_ctl, 8'h40);
		load(i_key, kb);
		load(i_st, sb);
		run_len(n);
		check(n, 375);
		check({irq, irq_level}, 3'b101);
		rd_chk(i_st, sb[0]);
		rd_chk(i_key, kb[0]);
		@(posedge clk);
		check({dma_req, irq}, 2'b00);
		end_of_test();
	end
endmodule : tb_top

`default_nettype wire
